/* rtl/boot_cmd_top.sv */
`timescale 1ns/1ps
`include "bpc_defs.svh"
module boot_cmd_top #(
  // Arbitrary identity values
  parameter logic [15:0] MAKER_CODE  = 16'h005A,
  parameter logic [15:0] DEVICE_CODE = 16'h0123
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  // Host access port
  input  wire logic             wr_en,
  input  wire logic             rd_en,
  input  wire logic [15:0]      addr,
  input  wire logic [15:0]      wdata,
  output logic      [15:0]      rdata,
  output logic                  rvalid,
  // Flash array engine
  output logic                  load_req,
  output logic [`BLOCK_W-1:0]   load_block,
  output logic [`PAGE_W-1:0]    load_page,
  input  wire logic             array_done,
  input  wire logic             boot_done,
  input  wire logic             fill_valid,
  input  wire logic             fill_to_boot,
  input  wire logic [9:0]       fill_addr,
  input  wire logic [15:0]      fill_data,
  // Error check results, valid with a done pulse
  input  wire logic [1:0][1:0]  err_main,
  input  wire logic [1:0][1:0]  err_spare,
  input  wire logic [1:0][7:0]  word_pos,
  input  wire logic [1:0][3:0]  line_pos,
  input  wire logic [1:0][1:0]  spare_sel,
  // Protection status of the current block
  input  wire logic [2:0]       wp_status,
  // Status
  output logic                  load_done_flag,
  output logic                  busy
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  bpc_pkg::cmd_state_e state;      // Interpreter state
  bpc_pkg::cmd_state_e next_state; // Its next value
  bpc_pkg::rd_src_e    rd_src;     // Data source of pending read
  logic                in_bp;      // Address in boot partition
  logic                in_dp;      // Address in data partition
  logic                bp_wr;      // Command cycle
  logic                reg_wr;     // Register store
  logic                cmd_reset;  // Reset command seen
  logic                soft_rst;   // Registered reset pulse
  logic                load_go;    // Second load cycle seen
  logic                load_fin;   // Array finished our load
  logic                ecc_take;   // Any load finished
  logic [`PAGE_W-1:0]  flash_page_address;        // Flash page address
  logic [1:0]          flash_sector_address;        // Sector address, stored only
  logic [15:0]         buf_sel;    // Buffer sector fields
  logic [15:0]         ident_val;  // Identification output
  logic [15:0]         reg_val;    // Register read value
  logic [15:0]         direct_val; // Non-memory read value
  logic [15:0]         direct_q;   // Captured direct value
  logic                rd_pend;    // Read in flight
  logic [15:0]         boot_rd;    // Boot buffer read word
  logic [15:0]         data_rd;    // Data buffer read word
  logic                data_we;    // Data buffer write enable
  logic [8:0]          data_wa;    // Data buffer write address
  logic [15:0]         data_wd;    // Data buffer write data
  logic [15:0]         ecc_sum;    // Error summary word
  logic [1:0][15:0]    main_pos;   // Main area results
  logic [1:0][15:0]    spare_pos;  // Spare area results

  //////////////////////////////////////////////////////////////////////////
  // Address decode
  // Boot partition: low window plus small high window
  assign in_bp = (addr <= `BP_LO_END) ||
                 (addr >= `BP_HI_START && addr <= `BP_HI_END); // RULE_02
  // Data partition: the first data buffer
  assign in_dp = (addr >= `DP_START) && (addr <= `DP_END);

  // Only boot partition writes are command cycles
  assign bp_wr  = wr_en && in_bp; // RULE_01
  // Everything else is a plain store
  assign reg_wr = wr_en && !in_bp && !in_dp; // RULE_04

  // Reset command is a single cycle in any state
  assign cmd_reset = bp_wr && (wdata == `CMD_RESET); // RULE_07

  // Load starts only once the second cycle is in
  assign load_go = (state == bpc_pkg::ST_PEND) && bp_wr &&
                   (wdata == `CMD_LOAD_GO); // RULE_05 RULE_08

  // Array completion counts only for a load we asked for
  assign load_fin = (state == bpc_pkg::ST_LOAD) && array_done;

  // Host loads and the boot load both refresh results
  assign ecc_take = load_fin || boot_done; // RULE_19

  //////////////////////////////////////////////////////////////////////////
  // Command sequencer
  // Next state from the current command cycle
  always_comb begin
    next_state = state;
    case (state)
      bpc_pkg::ST_READY: begin
        // First cycle of a sequence
        if (bp_wr) begin
          if (wdata == `CMD_LOAD) begin
            next_state = bpc_pkg::ST_PEND;
          end else if (wdata == `CMD_IDENT) begin
            next_state = bpc_pkg::ST_IDENT; // RULE_13
          end
        end
      end
      bpc_pkg::ST_PEND: begin
        // Wait quietly for the confirming cycle
        if (bp_wr) begin
          if (wdata == `CMD_LOAD_GO) begin
            next_state = bpc_pkg::ST_LOAD; // RULE_22
          end else begin
            next_state = bpc_pkg::ST_READY; // RULE_06
          end
        end
      end
      bpc_pkg::ST_LOAD: begin
        // Command cycles other than reset are ignored while loading
        if (load_fin) begin
          next_state = bpc_pkg::ST_READY;
        end
      end
      bpc_pkg::ST_IDENT: begin
        // Any write strobe leaves identification mode;
        // a boot write is then decoded as a fresh command
        if (wr_en) begin
          if (bp_wr && wdata == `CMD_LOAD) begin
            next_state = bpc_pkg::ST_PEND;
          end else if (bp_wr && wdata == `CMD_IDENT) begin
            next_state = bpc_pkg::ST_IDENT;
          end else begin
            next_state = bpc_pkg::ST_READY; // RULE_14
          end
        end
      end
      default: begin
        next_state = bpc_pkg::ST_READY;
      end
    endcase
    // Reset command overrides any sequence in progress
    if (cmd_reset) begin
      next_state = bpc_pkg::ST_READY; // RULE_07
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= bpc_pkg::ST_READY;
    end else begin
      state <= next_state;
    end
  end

  // Sequencer pulses and busy; the reset command lands one cycle late
  // as a clean pulse so it never races the write that carried it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      soft_rst <= 1'b0;
      load_req <= 1'b0;
      busy     <= 1'b0;
    end else begin
      soft_rst <= cmd_reset; // RULE_07
      load_req <= load_go && !cmd_reset; // RULE_05 RULE_08
      busy     <= (next_state == bpc_pkg::ST_PEND) ||
                  (next_state == bpc_pkg::ST_LOAD);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Address registers
  // Load source block, and the buffer word that the load ignores
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      load_block <= '0; // RULE_12
      buf_sel    <= 16'h0000;
    end else if (soft_rst) begin
      load_block <= '0; // RULE_07
      buf_sel    <= 16'h0000;
    end else if (reg_wr && addr == `REG_BLOCK) begin
      load_block <= wdata[`BLOCK_W-1:0];
    end else if (reg_wr && addr == `REG_BUFFER) begin
      buf_sel <= wdata; // RULE_09
    end
  end

  // Page and sector address; the page steps after each host load, not the boot load
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flash_page_address <= '0; // RULE_12
      flash_sector_address <= 2'h0;
    end else if (soft_rst) begin
      flash_page_address <= '0; // RULE_07
      flash_sector_address <= 2'h0;
    end else if (load_fin) begin
      // Page field wraps, so the block never changes
      flash_page_address <= flash_page_address + `PAGE_W'(1); // RULE_10 RULE_11
    end else if (reg_wr && addr == `REG_PAGE) begin
      flash_page_address <= wdata[`PAGE_LSB +: `PAGE_W];
      flash_sector_address <= wdata[1:0];
    end
  end

  // Engine sees block and page only; sector and buffer fields stay out
  assign load_page = flash_page_address; // RULE_09

  //////////////////////////////////////////////////////////////////////////
  // Load completion flag
  // Sticky; a completion in a register-clear cycle still sets it, but the reset command wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      load_done_flag <= `DONE_COLD;
    end else if (soft_rst) begin
      load_done_flag <= 1'b0; // RULE_21
    end else if (ecc_take) begin
      load_done_flag <= 1'b1; // RULE_21
    end else if (reg_wr && addr == `REG_INT && !wdata[`DONE_BIT]) begin
      load_done_flag <= 1'b0; // RULE_21
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Error results
  // Result registers, cleared by reset command too
  ecc_result_bank u_ecc (
    .mclk      (mclk),
    .rst       (rst),
    .clear     (soft_rst),
    .update    (ecc_take),
    .err_main  (err_main),
    .err_spare (err_spare),
    .word_pos  (word_pos),
    .line_pos  (line_pos),
    .spare_sel (spare_sel),
    .summary   (ecc_sum),
    .main_pos  (main_pos),
    .spare_pos (spare_pos)
  ); // RULE_16 RULE_19

  //////////////////////////////////////////////////////////////////////////
  // Buffers
  // Boot buffer: filled by the array, read from the boot partition;
  // high window folds onto index bit 9
  buffer_ram #(.AW(`BOOT_AW)) u_boot (
    .mclk    (mclk),
    .wr_en   (fill_valid && fill_to_boot),
    .wr_addr (fill_addr),
    .wr_data (fill_data),
    .rd_en   (rd_en && in_bp),
    .rd_addr ({addr[15], addr[8:0]}),
    .rd_data (boot_rd)
  );

  // Data buffer write: array fill takes priority over the host,
  // a host store racing a host load's fill is lost by design
  always_comb begin
    data_we = 1'b0;
    data_wa = addr[8:0];
    data_wd = wdata;
    if (fill_valid && !fill_to_boot) begin
      data_we = 1'b1; // RULE_11
      data_wa = fill_addr[8:0];
      data_wd = fill_data;
    end else if (wr_en && in_dp) begin
      data_we = 1'b1; // RULE_15
    end
  end

  // First data buffer, direct host access
  buffer_ram #(.AW(`DATA_AW)) u_data (
    .mclk    (mclk),
    .wr_en   (data_we),
    .wr_addr (data_wa),
    .wr_data (data_wd),
    .rd_en   (rd_en && in_dp),
    .rd_addr (addr[8:0]),
    .rd_data (data_rd)
  ); // RULE_15

  //////////////////////////////////////////////////////////////////////////
  // Read path
  // Identification words by read address
  always_comb begin
    case (addr)
      `ID_ADDR_MAKER:   ident_val = MAKER_CODE; // RULE_13
      `ID_ADDR_DEVICE:  ident_val = DEVICE_CODE; // RULE_13
      `ID_ADDR_PROTECT: ident_val = {13'h0000, wp_status}; // RULE_13
      default:          ident_val = 16'h0000;
    endcase
  end

  // Register map; unmapped addresses read zero
  always_comb begin
    case (addr)
      `REG_MAKER:       reg_val = MAKER_CODE;
      `REG_DEVICE:      reg_val = DEVICE_CODE;
      `REG_BLOCK:       reg_val = {7'h00, load_block};
      `REG_PAGE:        reg_val = {8'h00, flash_page_address, flash_sector_address};
      `REG_BUFFER:      reg_val = buf_sel;
      `REG_INT:         reg_val = {8'h00, load_done_flag, 7'h00};
      `REG_PROTECT:     reg_val = {13'h0000, wp_status};
      `REG_ECC_SUM:     reg_val = ecc_sum;
      `REG_ECC_MAIN_A:  reg_val = main_pos[0];
      `REG_ECC_SPARE_A: reg_val = spare_pos[0];
      `REG_ECC_MAIN_B:  reg_val = main_pos[1];
      `REG_ECC_SPARE_B: reg_val = spare_pos[1];
      default:          reg_val = 16'h0000;
    endcase
  end

  // Boot reads show a command's output once one is open
  always_comb begin
    if (in_bp && state == bpc_pkg::ST_IDENT) begin
      direct_val = ident_val; // RULE_03
    end else if (in_bp) begin
      direct_val = 16'h0000; // RULE_03
    end else begin
      direct_val = reg_val;
    end
  end

  // First read stage: pick the source while memories fetch
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_pend  <= 1'b0;
      rd_src   <= bpc_pkg::RS_DIRECT;
      direct_q <= 16'h0000;
    end else begin
      rd_pend  <= rd_en;
      direct_q <= direct_val;
      if (in_bp && state == bpc_pkg::ST_READY) begin
        rd_src <= bpc_pkg::RS_BOOT; // RULE_03
      end else if (in_dp) begin
        rd_src <= bpc_pkg::RS_DATA; // RULE_15
      end else begin
        rd_src <= bpc_pkg::RS_DIRECT;
      end
    end
  end

  // Second read stage: registered output, two edges after the request
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata  <= 16'h0000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd_pend;
      if (rd_pend) begin
        case (rd_src)
          bpc_pkg::RS_BOOT:   rdata <= boot_rd;
          bpc_pkg::RS_DATA:   rdata <= data_rd;
          bpc_pkg::RS_DIRECT: rdata <= direct_q;
          default:            rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule : boot_cmd_top

/* rtl/bpc_defs.svh */
`ifndef BPC_DEFS_SVH
`define BPC_DEFS_SVH
// What this block does
// RULE_01: Commands accepted only at boot-partition addresses
// RULE_02: Boot partition is 0000-01FF and 8000-800F
// RULE_03: Boot reads show buffer only without command
// RULE_04: Other writes are plain buffer/register stores
// RULE_05: Execute only after all command cycles arrive
// RULE_06: Bad boot write aborts sequence, back to ready
// RULE_07: Write 00F0h resets all registers and state
// RULE_08: 00E0h then 0000h loads page to buffer
// RULE_09: Load uses block and page addresses only
// RULE_10: Page address increments after load, stays in-block
// RULE_11: Load confined to block, fills first buffer
// RULE_12: Block and page addresses reset to zero
// RULE_13: 0090h then read gives maker, device, protection
// RULE_14: Any write strobe ends identification mode
// RULE_15: Data partition accesses go straight to buffer
// RULE_16: Two-bit error state per selected sector
// RULE_17: Main result gives word and data line
// RULE_18: Spare result gives word select and line
// RULE_19: Boot load also refreshes error results
// RULE_20: Codes: none, correctable, uncorrectable, reserved
// RULE_21: Load completion sets sticky done flag
// RULE_22: Pending state between two command cycles
// RULE_23: Reserved result bits read as zero

// Address map (16-bit word addresses)
`define BP_LO_END        16'h01FF
`define BP_HI_START      16'h8000
`define BP_HI_END        16'h800F
`define DP_START         16'h0200
`define DP_END           16'h03FF
// Command codes
`define CMD_RESET        16'h00F0
`define CMD_LOAD         16'h00E0
`define CMD_LOAD_GO      16'h0000
`define CMD_IDENT        16'h0090
// Identification read addresses
`define ID_ADDR_MAKER    16'h0000
`define ID_ADDR_DEVICE   16'h0001
`define ID_ADDR_PROTECT  16'h0002
// Register offsets
`define REG_MAKER        16'hF000
`define REG_DEVICE       16'hF001
`define REG_BLOCK        16'hF100
`define REG_PAGE         16'hF107
`define REG_BUFFER       16'hF200
`define REG_INT          16'hF241
`define REG_PROTECT      16'hF24E
`define REG_ECC_SUM      16'hFF00
`define REG_ECC_MAIN_A   16'hFF01
`define REG_ECC_SPARE_A  16'hFF02
`define REG_ECC_MAIN_B   16'hFF03
`define REG_ECC_SPARE_B  16'hFF04
// Fields and reset values
`define DONE_BIT         7
`define DONE_COLD        1'b1
`define BLOCK_W          9
`define PAGE_W           6
`define PAGE_LSB         2
`define BOOT_AW          10
`define DATA_AW          9
`endif

/* rtl/bpc_pkg.sv */
package bpc_pkg;
  // Command interpreter states, one-hot
  typedef enum logic [3:0] {
    ST_READY = 4'h1,
    ST_PEND  = 4'h2,
    ST_LOAD  = 4'h4,
    ST_IDENT = 4'h8
  } cmd_state_e;
  // Source of read data, one-hot
  typedef enum logic [2:0] {
    RS_DIRECT = 3'h1,
    RS_BOOT   = 3'h2,
    RS_DATA   = 3'h4
  } rd_src_e;
endpackage : bpc_pkg

/* rtl/buffer_ram.sv */
`timescale 1ns/1ps
module buffer_ram #(
  parameter int AW = 9
) (
  input  wire logic          mclk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [15:0]   wr_data,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [15:0]   rd_data
);
  // Storage, no reset so it maps to block RAM
  logic [15:0] mem [0:(1<<AW)-1];

  // Write port
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge mclk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : buffer_ram

/* rtl/ecc_result_bank.sv */
`timescale 1ns/1ps
module ecc_result_bank (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             update,
  input  wire logic [1:0][1:0]  err_main,
  input  wire logic [1:0][1:0]  err_spare,
  input  wire logic [1:0][7:0]  word_pos,
  input  wire logic [1:0][3:0]  line_pos,
  input  wire logic [1:0][1:0]  spare_sel,
  output wire logic [15:0]      summary,
  output wire logic [1:0][15:0] main_pos,
  output wire logic [1:0][15:0] spare_pos
);
  // Upper summary byte is reserved
  assign summary[15:8] = 8'h00; // RULE_23

  genvar g;
  // One identical slice per selected sector
  generate
    for (g = 0; g < 2; g++) begin : g_sector
      logic [3:0]  state_q;  // {main, spare} error codes
      logic [11:0] main_q;   // {word, line}
      logic [5:0]  spare_q;  // {word select, line}
      // Results captured from the error check of a load
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          state_q <= 4'h0;
          main_q  <= 12'h000;
          spare_q <= 6'h00;
        end else if (clear) begin
          state_q <= 4'h0;
          main_q  <= 12'h000;
          spare_q <= 6'h00;
        end else if (update) begin
          // Codes pass through as coded, 11 kept reserved
          state_q <= {err_main[g], err_spare[g]}; // RULE_16 RULE_20
          main_q  <= {word_pos[g], line_pos[g]}; // RULE_17
          spare_q <= {spare_sel[g], line_pos[g]}; // RULE_18
        end
      end
      assign summary[g*4 +: 4] = state_q;
      assign main_pos[g]  = {4'h0, main_q}; // RULE_23
      assign spare_pos[g] = {10'h000, spare_q}; // RULE_23
    end
  endgenerate
endmodule : ecc_result_bank

/* testbench/boot_cmd_monitor.sv */
`timescale 1ns/1ps
`include "bpc_defs.svh"
module boot_cmd_monitor (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        rvalid,
  input wire logic        load_req,
  input wire logic [8:0]  load_block,
  input wire logic [5:0]  load_page,
  input wire logic        array_done,
  input wire logic        load_done_flag,
  input wire logic        busy
);
  // Both windows of the boot partition
  function automatic logic bp(input logic [15:0] a);
    return a <= `BP_LO_END || (a >= `BP_HI_START && a <= `BP_HI_END);
  endfunction : bp
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_read_lat:
  assert property (rd_en |-> ##2 rvalid) else $error("read answer late");
  chk_read_cause:
  assert property (rvalid |-> $past(rd_en, 2)) else $error("stray answer");
  chk_rdata_hold:
  assert property (!rvalid |-> $stable(rdata)) else $error("rdata moved");
  chk_load_start:
  assert property ((wr_en && bp(addr) && wdata == `CMD_LOAD && !busy)
    ##1 !wr_en ##1 (wr_en && bp(addr) && wdata == `CMD_LOAD_GO)
    |=> load_req) else $error("load not started");
  chk_load_cause:
  assert property (load_req |-> busy && !$past(load_req) && $past(wr_en
    && bp(addr) && wdata == `CMD_LOAD_GO)) else $error("early load");
  chk_pend_busy:
  assert property (wr_en && bp(addr) && wdata == `CMD_LOAD && !busy
    |=> busy) else $error("no pending state");
  chk_page_step:
  assert property (array_done && busy |=> load_page ==
    $past(load_page) + 6'h01) else $error("page not stepped");
  chk_load_end:
  assert property (array_done && busy |=> !busy && load_done_flag)
    else $error("load end wrong");
  chk_soft_reset:
  assert property (wr_en && bp(addr) && wdata == `CMD_RESET |-> ##2
    (!load_done_flag && load_page == 6'h00 && load_block == 9'h000))
    else $error("reset command failed");
endmodule : boot_cmd_monitor
bind boot_cmd_top boot_cmd_monitor mon (.mclk, .rst, .wr_en, .rd_en,
  .addr, .wdata, .rdata, .rvalid, .load_req, .load_block, .load_page,
  .array_done, .load_done_flag, .busy);

/* testbench/boot_partition_command_ecc_report_tb_top.sv */
`timescale 1ns/1ps
`include "bpc_defs.svh"
module boot_partition_command_ecc_report_tb_top;
  localparam logic [15:0] MK = 16'h0A5C; // Arbitrary maker word
  localparam logic [15:0] DV = 16'h0B17; // Arbitrary device word
  logic mclk, rst, wr_en, rd_en, rvalid, load_req, array_done, boot_done;
  logic fill_valid, fill_to_boot, load_done_flag, busy;
  logic [15:0] addr, wdata, rdata, fill_data, q, da, dv;
  logic [9:0] fill_addr;
  logic [8:0] load_block, blk;
  logic [5:0] load_page, pg;
  logic [1:0][1:0] err_main, err_spare, spare_sel;
  logic [1:0][7:0] word_pos;
  logic [1:0][3:0] line_pos;
  logic [2:0] wp;
  int seed, error_cnt, comparisons;
  boot_cmd_top #(.MAKER_CODE(MK), .DEVICE_CODE(DV)) DUT (.mclk, .rst,
    .wr_en, .rd_en, .addr, .wdata, .rdata, .rvalid, .load_req,
    .load_block, .load_page, .array_done, .boot_done, .fill_valid,
    .fill_to_boot, .fill_addr, .fill_data, .err_main, .err_spare,
    .word_pos, .line_pos, .spare_sel, .wp_status(wp), .load_done_flag,
    .busy);
  flash_engine_model eng (.mclk, .rst, .load_req, .load_page,
    .array_done, .boot_done, .fill_valid, .fill_to_boot, .fill_addr,
    .fill_data, .err_main, .err_spare, .word_pos, .line_pos, .spare_sel);
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    comparisons++;
    if (g !== x) begin
      error_cnt++;
      $display("wrong value t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  // Used-up bound: a mismatch, then stop
  task automatic give_up();
    error_cnt++;
    end_sim();
  endtask : give_up
  // One write, spaced so strobes never merge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge mclk);
    wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a);
    @(negedge mclk);
    {rd_en, addr} = {1'b1, a};
    @(negedge mclk);
    rd_en = 1'b0;
    for (int i = 0; i < 4 && rvalid !== 1'b1; i++) @(negedge mclk);
    if (rvalid !== 1'b1) give_up();
    q = rdata;
  endtask : rd
  // Random address in either boot window
  function automatic logic [15:0] bpa(input logic [15:0] r);
    return r[12] ? {12'h800, r[3:0]} : {7'h00, r[8:0]};
  endfunction : bpa
  // Expected error result word r for a page
  function automatic logic [15:0] ecc(input logic [5:0] p, input int r);
    logic [1:0] e;
    e = p[1:0];
    case (r)
      0: return {8'h00, ~e, e, e, ~e};
      1: return {6'h00, p, p[3:0]};
      2: return {11'h000, p[0], p[3:0]};
      3: return {4'h0, 8'hC3, 4'h5};
      default: return {10'h000, 2'b01, 4'h5};
    endcase
  endfunction : ecc
  task automatic ecc_all(input logic [5:0] p, input logic z);
    for (int r = 0; r < 5; r++) begin
      rd(`REG_ECC_SUM + 16'(r));
      chk(q, z ? 16'h0000 : ecc(p, r));
    end
  endtask : ecc_all
  task automatic wait_idle();
    for (int i = 0; i < 40 && busy !== 1'b0; i++) @(negedge mclk);
    if (busy !== 1'b0) give_up();
  endtask : wait_idle
  //////////////////////////////////////////////////////////////////////
  initial begin
    seed = 90531;
    {wr_en, rd_en, addr, wdata, error_cnt, comparisons} = '0;
    wp = 3'($random(seed));
    rst = 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk) rst = 1'b0;
    for (int i = 0; i < 60 && boot_done !== 1'b1; i++) @(negedge mclk);
    if (boot_done !== 1'b1) give_up();
    // Cold defaults and boot load results
    rd(`REG_INT);
    chk(q, 16'h0080);
    rd(`REG_PAGE);
    chk(q, 16'h0000);
    ecc_all(6'h3F, 1'b0);
    for (int i = 0; i < 4; i++) begin
      rd(16'(i));
      chk(q, {4'hA, 2'h0, 6'h3F, 4'(i)});
    end
    $display("boot load test done");
    // Reset command clears flag and results
    wr(bpa(16'($random(seed))), `CMD_RESET);
    rd(`REG_INT);
    chk(q, 16'h0000);
    ecc_all(6'h00, 1'b1);
    $display("reset command test done");
    // Loads from near the block end, page wraps inside the block
    blk = 9'($random(seed));
    wr(`REG_BLOCK, {7'h00, blk});
    wr(`REG_PAGE, 16'h00F8);
    wr(`REG_BUFFER, 16'($random(seed))); // Ignored by the load
    for (int k = 0; k < 4; k++) begin
      pg = 6'h3E + 6'(k);
      wr(bpa(16'($random(seed))), `CMD_LOAD);
      wr(bpa(16'($random(seed))), `CMD_LOAD_GO);
      wait_idle();
      rd(`REG_PAGE);
      chk(q, {8'h00, pg + 6'h01, 2'b00});
      rd(`REG_BLOCK);
      chk(q, {7'h00, blk});
      for (int i = 0; i < 4; i++) begin
        rd(`DP_START + 16'(i));
        chk(q, {4'hA, 2'h0, pg, 4'(i)});
      end
      ecc_all(pg, 1'b0);
      rd(`REG_INT);
      chk(q, 16'h0080);
      wr(`REG_INT, 16'h0000);
    end
    $display("page load test done");
    // Broken sequence must not load
    wr(bpa(16'h0010), `CMD_LOAD);
    wr(bpa(16'h1020), 16'h1234);
    wr(bpa(16'h0030), `CMD_LOAD_GO);
    repeat (8) @(negedge mclk);
    chk({15'h0000, busy}, 16'h0000);
    rd(`REG_PAGE);
    chk(q, 16'h0008);
    // Identification words, then a write ends the mode
    wr(bpa(16'h0044), `CMD_IDENT);
    rd(`ID_ADDR_MAKER);
    chk(q, MK);
    rd(`ID_ADDR_DEVICE);
    chk(q, DV);
    rd(`ID_ADDR_PROTECT);
    chk(q, {13'h0000, wp});
    wr(`DP_END, 16'h5A5A);
    rd(16'h0002);
    chk(q, {4'hA, 2'h0, 6'h3F, 4'h2});
    $display("command test done");
    // Unmapped, read-only and random data partition traffic
    rd(16'h4000);
    chk(q, 16'h0000);
    wr(`REG_ECC_MAIN_B, 16'hFFFF);
    rd(`REG_ECC_MAIN_B);
    chk(q, ecc(6'h01, 3));
    for (int k = 0; k < 6; k++) begin
      dv = 16'($random(seed));
      da = `DP_START + {7'h00, 9'($random(seed))};
      wr(da, dv);
      wr({7'h00, da[8:0]}, ~dv | 16'h1000); // Boot twin, no command
      rd(da);
      chk(q, dv);
    end
    $display("data partition test done");
    end_sim();
  end
endmodule : boot_partition_command_ecc_report_tb_top

/* testbench/flash_engine_model.sv */
`timescale 1ns/1ps
module flash_engine_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       load_req,
  input  wire logic [5:0] load_page,
  output logic            array_done,
  output logic            boot_done,
  output logic            fill_valid,
  output logic            fill_to_boot,
  output logic [9:0]      fill_addr,
  output logic [15:0]     fill_data,
  output logic [1:0][1:0] err_main,
  output logic [1:0][1:0] err_spare,
  output logic [1:0][7:0] word_pos,
  output logic [1:0][3:0] line_pos,
  output logic [1:0][1:0] spare_sel
);
  logic [5:0] pg; // Page being fetched
  logic [1:0] e;  // Error code picked from the page
  // Four fill words, then results with the done pulse
  task automatic run(input logic boot);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      fill_valid <= 1'b1;
      fill_to_boot <= boot;
      fill_addr <= 10'(i);
      fill_data <= {4'hA, 2'h0, pg, 4'(i)};
    end
    @(posedge mclk);
    fill_valid <= 1'b0;
    fill_data <= ~fill_data; // Released bus never holds last word
    // Odd pages answer slowly
    repeat (pg[0] ? 6 : 0) @(posedge mclk);
    e = pg[1:0];
    err_main <= {~e, e};
    err_spare <= {e, ~e};
    word_pos <= {8'hC3, 2'h0, pg};
    line_pos <= {4'h5, pg[3:0]};
    spare_sel <= {2'b01, 1'b0, pg[0]};
    if (boot) boot_done <= 1'b1;
    else array_done <= 1'b1;
    @(posedge mclk);
    {boot_done, array_done} <= 2'b00;
    err_main <= ~err_main; // Main codes and word positions only hold with the pulse
    word_pos <= ~word_pos;
  endtask : run
  // Boot load after reset, then serve each request
  initial begin
    {array_done, boot_done, fill_valid, fill_to_boot} = 4'h0;
    {fill_addr, fill_data, err_main, err_spare} = '0;
    {word_pos, line_pos, spare_sel} = '0;
    @(negedge rst);
    pg = 6'h3F;
    run(1'b1);
    forever begin
      @(posedge mclk);
      if (load_req) begin
        pg = load_page;
        run(1'b0);
      end
    end
  end
endmodule : flash_engine_model
